// ===== rtl/epio_top.sv
// Purpose: eight-port parallel i/o block behind a byte-wide i/o bus
// Assumes: bus strobes and all pins synchronous to clock_in
// Assumes: monitor_mode_in may change while running
// Notes: terminal lines are split into in, out and active-low enable
// Notes: strobe delay is the shortest legal one, a rewrite restarts it
// Notes: status flag 0 means new data, reset shows every port as read
// Notes: a gate held high keeps its flag clear, reads cannot set it
//
// Contract
// - eight ports, write and read latch each
// - i/o write loads the addressed write latch
// - external capture gate loads the read latch
// - strobe low 1.0-1.5 us later, 1.0 us
// - low drive enable drives the write latch
// - port 6 read shows all status flags
// - select when A7..A3 match base switches
// - port k answers at base plus k
// - switch on needs 1, off needs 0
// - spare three switches read on port 4
// - eight switch bank read on port 7
// - leds show port 7 write latch
// - couplers appear as port 4 bits 3, 4
// - relays follow port 1 bits 0, 1
// - port 6 monitor by default, optional plain
// - drive when enable low or control bit set
// - read latch follows while gate high
// - gate high clears the status flag
// - processor read sets the status flag
`timescale 1ns/100ps
`include "epio_cfg.svh"

module epio_top (
	input wire logic clock_in,
	input wire logic rst_in,
	// i/o bus side
	input wire logic [7:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_write_in,
	input wire logic bus_read_in,
	output logic [7:0] bus_rdata_out,
	output logic bus_rdata_valid_out,
	output logic bus_select_out,
	// board straps and switches
	input wire logic [4:0] base_switch_in,
	input wire logic [2:0] spare_switch_in,
	input wire logic [7:0] switch_bank_in,
	input wire logic monitor_mode_in,
	input wire logic [1:0] coupler_in,
	// terminal side, port k uses bits 8k+7 .. 8k
	input wire logic [63:0] terminal_data_line_in,
	output logic [63:0] terminal_data_line_out,
	output logic [7:0] terminal_data_oe_n_out,
	input wire logic [7:0] drive_enable_n_in,
	input wire logic [7:0] capture_gate_in,
	output logic [7:0] write_strobe_n_out,
	// on-board loads
	output logic [7:0] led_out,
	output logic [1:0] relay_out
);

	// board select: every base switch must match its address line
	function automatic logic board_hit(input logic [7:0] addr, input logic [4:0] base);
		board_hit = (addr[7:3] == base);
	endfunction

	// decoded one-hot port select, gated by board select
	function automatic logic [7:0] port_onehot(input logic [7:0] addr, input logic [4:0] base);
		port_onehot = 8'h00;
		if (board_hit(addr, base)) begin
			port_onehot[addr[2:0]] = 1'b1;
		end
	endfunction

	// port 6 belongs to the control logic while monitor mode is on
	function automatic logic plain_port(input int k, input logic mon);
		plain_port = !(k == `EPIO_PORT_MONITOR && mon);
	endfunction

	logic [7:0] wr_sel;
	logic [7:0] rd_sel;
	logic monitor_wr;

	// strobes qualified by address decode; port 6 diverted in monitor mode
	always_comb begin
		wr_sel = bus_write_in ? port_onehot(bus_addr_in, base_switch_in) : 8'h00;
		rd_sel = bus_read_in ? port_onehot(bus_addr_in, base_switch_in) : 8'h00;
		monitor_wr = monitor_mode_in & wr_sel[`EPIO_PORT_MONITOR];
		bus_select_out = board_hit(bus_addr_in, base_switch_in) & (bus_write_in | bus_read_in);
	end

	// write latches and port 6 control bits
	epio_pkg::epio_byte_t wr_latch_reg [8];
	epio_pkg::epio_byte_t wr_latch_next [8];
	epio_pkg::epio_byte_t ctrl_reg;
	epio_pkg::epio_byte_t ctrl_next;

	// next latch values, at most one write per cycle
	always_comb begin
		for (int k = 0; k < `EPIO_NUM_PORTS; k++) begin
			wr_latch_next[k] = wr_latch_reg[k];
			if (wr_sel[k] && plain_port(k, monitor_mode_in)) begin
				wr_latch_next[k] = bus_wdata_in;
			end
		end
		// control bits only exist in monitor mode
		ctrl_next = ctrl_reg;
		if (monitor_wr) begin
			ctrl_next = bus_wdata_in;
		end
		// plain mode: software enables are not available
		if (!monitor_mode_in) begin
			ctrl_next = `EPIO_CTRL_RST;
		end
	end

	// latches clear only on reset
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int k = 0; k < `EPIO_NUM_PORTS; k++) begin
				wr_latch_reg[k] <= `EPIO_LATCH_RST;
			end
			ctrl_reg <= `EPIO_CTRL_RST;
		end else begin
			for (int k = 0; k < `EPIO_NUM_PORTS; k++) begin
				wr_latch_reg[k] <= wr_latch_next[k];
			end
			ctrl_reg <= ctrl_next;
		end
	end

	// read latches and status flags; flag 1 means read, 0 means new data
	epio_pkg::epio_byte_t rd_latch_reg [8];
	epio_pkg::epio_byte_t rd_latch_next [8];
	logic [7:0] status_reg;
	logic [7:0] status_next;

	// transparent while the gate is high, holds once it drops
	always_comb begin
		for (int k = 0; k < `EPIO_NUM_PORTS; k++) begin
			rd_latch_next[k] = rd_latch_reg[k];
			if (capture_gate_in[k]) begin
				rd_latch_next[k] = terminal_data_line_in[8*k +: 8];
			end
			status_next[k] = status_reg[k];
			if (rd_sel[k] && plain_port(k, monitor_mode_in)) begin
				status_next[k] = 1'b1;
			end
			// a gate still high keeps the flag clear, it beats the read
			if (capture_gate_in[k]) begin
				status_next[k] = 1'b0;
			end
		end
	end

	// flags reset to read, so no port claims new data
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int k = 0; k < `EPIO_NUM_PORTS; k++) begin
				rd_latch_reg[k] <= `EPIO_LATCH_RST;
			end
			status_reg <= `EPIO_STATUS_RST;
		end else begin
			for (int k = 0; k < `EPIO_NUM_PORTS; k++) begin
				rd_latch_reg[k] <= rd_latch_next[k];
			end
			status_reg <= status_next;
		end
	end

	// read data mux; special ports overlay on-board devices
	epio_pkg::epio_byte_t rdata_reg;
	epio_pkg::epio_byte_t rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	epio_pkg::epio_byte_t sel_byte;

	// byte picked by the low address bits, before the read edge
	always_comb begin
		sel_byte = rd_latch_reg[bus_addr_in[2:0]];
		case (bus_addr_in[2:0])
			`EPIO_PORT_SWITCH_OPTO: begin
				sel_byte[`EPIO_SW3_LSB +: 3] = spare_switch_in;
				sel_byte[`EPIO_OPTO_LSB +: 2] = coupler_in;
			end
			`EPIO_PORT_MONITOR: begin
				if (monitor_mode_in) begin
					sel_byte = status_reg;
				end
			end
			`EPIO_PORT_PANEL: begin
				sel_byte = switch_bank_in;
			end
			default: begin
			end
		endcase
		// answer only for a decoded read
		rvalid_next = |rd_sel;
		rdata_next = rdata_reg;
		if (|rd_sel) begin
			rdata_next = sel_byte;
		end
	end

	// registered answer, one cycle after the read strobe
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// answer pins straight from the flops
	assign bus_rdata_out = rdata_reg;
	assign bus_rdata_valid_out = rvalid_reg;

	// software enables vanish the moment monitor mode is left
	logic [7:0] sw_enable;
	assign sw_enable = ctrl_reg & {8{monitor_mode_in}};

	// counts cut to the counter width on purpose
	localparam logic [`EPIO_CNT_W-1:0] stb_delay_cyc = `EPIO_CNT_W'(`EPIO_STROBE_DELAY_CYC);
	localparam logic [`EPIO_CNT_W-1:0] stb_width_cyc = `EPIO_CNT_W'(`EPIO_STROBE_WIDTH_CYC);

	// per-port strobe sequencer; a new write restarts the delay
	genvar g;
	generate
		for (g = 0; g < `EPIO_NUM_PORTS; g++) begin : gen_port
			// state of this port's strobe
			epio_pkg::epio_stb_e stb_state_reg;
			epio_pkg::epio_stb_e stb_state_next;
			logic [`EPIO_CNT_W-1:0] stb_cnt_reg;
			logic [`EPIO_CNT_W-1:0] stb_cnt_next;
			logic stb_n_reg;
			logic stb_n_next;

			// counts from the bus clock, no analog one-shot
			always_comb begin
				stb_state_next = stb_state_reg;
				stb_cnt_next = stb_cnt_reg;
				stb_n_next = 1'b1;
				case (stb_state_reg)
					epio_pkg::EPIO_STB_IDLE: begin
						stb_n_next = 1'b1;
					end
					epio_pkg::EPIO_STB_DELAY: begin
						stb_cnt_next = stb_cnt_reg - 8'h01;
						if (stb_cnt_reg == 8'h01) begin
							stb_state_next = epio_pkg::EPIO_STB_LOW;
							stb_cnt_next = stb_width_cyc;
							stb_n_next = 1'b0;
						end
					end
					epio_pkg::EPIO_STB_LOW: begin
						stb_cnt_next = stb_cnt_reg - 8'h01;
						stb_n_next = 1'b0;
						if (stb_cnt_reg == 8'h01) begin
							stb_state_next = epio_pkg::EPIO_STB_IDLE;
							stb_n_next = 1'b1;
						end
					end
					default: begin
						stb_state_next = epio_pkg::EPIO_STB_IDLE;
						stb_cnt_next = '0;
					end
				endcase
				if (wr_sel[g]) begin
					stb_state_next = epio_pkg::EPIO_STB_DELAY;
					stb_cnt_next = stb_delay_cyc; // falls on the 100th edge, not before
					stb_n_next = 1'b1;
				end
			end

			// reset leaves every strobe inactive high
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					stb_state_reg <= epio_pkg::EPIO_STB_IDLE;
					stb_cnt_reg <= '0;
					stb_n_reg <= 1'b1;
				end else begin
					stb_state_reg <= stb_state_next;
					stb_cnt_reg <= stb_cnt_next;
					stb_n_reg <= stb_n_next;
				end
			end

			assign write_strobe_n_out[g] = stb_n_reg;
			// hardware and software enables wire-or onto the driver
			assign terminal_data_oe_n_out[g] = drive_enable_n_in[g] & ~sw_enable[g];
			assign terminal_data_line_out[8*g +: 8] = wr_latch_reg[g];
		end
	endgenerate

	// on-board loads hang off the write latches
	assign led_out = wr_latch_reg[`EPIO_PORT_PANEL];
	assign relay_out = wr_latch_reg[`EPIO_PORT_RELAY][1:0];

endmodule

// ===== common/epio_cfg.svh
// Purpose: constants for the eight-port parallel i/o block
// Assumes: 100 MHz system clock
// Notes: times in ns, cycle counts derived here
`ifndef EPIO_CFG_SVH
`define EPIO_CFG_SVH

`define EPIO_NUM_PORTS 8
`define EPIO_CLK_PERIOD_NS 10
// strobe falls 1.0 to 1.5 us after the write, stays low 1.0 us
`define EPIO_STROBE_DELAY_MIN_NS 1000
`define EPIO_STROBE_DELAY_MAX_NS 1500
`define EPIO_STROBE_WIDTH_NS 1000
// least delay rounds up, so the earliest edge still meets 1.0 us
`define EPIO_STROBE_DELAY_CYC \
	((`EPIO_STROBE_DELAY_MIN_NS + `EPIO_CLK_PERIOD_NS - 1) / `EPIO_CLK_PERIOD_NS)
`define EPIO_STROBE_WIDTH_CYC \
	((`EPIO_STROBE_WIDTH_NS + `EPIO_CLK_PERIOD_NS - 1) / `EPIO_CLK_PERIOD_NS)
`define EPIO_CNT_W 8

// port offsets from the base address
`define EPIO_PORT_RELAY 3'h1
`define EPIO_PORT_SWITCH_OPTO 3'h4
`define EPIO_PORT_MONITOR 3'h6
`define EPIO_PORT_PANEL 3'h7

// field positions in the switch and coupler input byte
`define EPIO_SW3_LSB 0
`define EPIO_OPTO_LSB 3

// reset values
`define EPIO_LATCH_RST 8'h00
`define EPIO_CTRL_RST 8'h00
`define EPIO_STATUS_RST 8'hff

`endif

// ===== common/epio_pkg.sv
// Purpose: shared types for the eight-port parallel i/o block
// Assumes: nothing beyond the cfg header
// Notes: constants live in epio_cfg.svh
package epio_pkg;

	typedef logic [7:0] epio_byte_t;

	// per-port strobe sequencer
	typedef enum logic [1:0] {
		EPIO_STB_IDLE,
		EPIO_STB_DELAY,
		EPIO_STB_LOW
	} epio_stb_e;

endpackage

// ===== test/epio_top_checker.sv
// Purpose: port assertions for the eight-port i/o block
// Assumes: one clock, reset active high
// Notes: strobe timing is watched on port 0 only
`timescale 1ns/100ps
module epio_top_chk (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_write_in,
	input wire logic bus_read_in,
	input wire logic bus_select_out,
	input wire logic bus_rdata_valid_out,
	input wire logic [4:0] base_switch_in,
	input wire logic monitor_mode_in,
	input wire logic [7:0] drive_enable_n_in,
	input wire logic [63:0] terminal_data_line_out,
	input wire logic [7:0] terminal_data_oe_n_out,
	input wire logic [7:0] write_strobe_n_out,
	input wire logic [7:0] led_out,
	input wire logic [1:0] relay_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic wr0;
	// decoded write to port 0, start of its strobe count
	assign wr0 = bus_write_in && bus_select_out && bus_addr_in[2:0] == 3'h0;
	// decode, latch, load, read-valid, strobe and drive-enable relations
	sel_decode_a: assert property (
		(bus_write_in || bus_read_in) |-> bus_select_out == (bus_addr_in[7:3] == base_switch_in))
		else $error("select wrong");
	wr_latch_a: assert property (
		bus_write_in && bus_select_out && bus_addr_in[2:0] == 3'h4
		|=> terminal_data_line_out[39:32] == $past(bus_wdata_in)) else $error("latch 4 wrong");
	led_show_a: assert property (
		bus_write_in && bus_select_out && bus_addr_in[2:0] == 3'h7
		|=> led_out == $past(bus_wdata_in)) else $error("leds wrong");
	relay_drive_a: assert property (
		bus_write_in && bus_select_out && bus_addr_in[2:0] == 3'h1
		|=> relay_out == $past(bus_wdata_in[1:0])) else $error("relays wrong");
	read_valid_a: assert property (
		bus_rdata_valid_out |-> $past(bus_read_in && bus_select_out)) else $error("stray valid");
	stb_delay_a: assert property ($fell(write_strobe_n_out[0]) |-> $past(wr0, 101))
		else $error("strobe delay wrong");
	stb_width_a: assert property (
		$fell(write_strobe_n_out[0]) |-> ##99 !write_strobe_n_out[0] ##1 write_strobe_n_out[0])
		else $error("strobe width wrong");
	drive_en_a: assert property (
		!monitor_mode_in |-> terminal_data_oe_n_out == drive_enable_n_in) else $error("oe wrong");
	cover property (bus_read_in && bus_select_out);
	cover property ($fell(write_strobe_n_out[0]));
	cover property (bus_write_in && !bus_select_out);
endmodule

bind epio_top epio_top_chk i_chk (.clock_in(clock_in), .rst_in(rst_in),
	.bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in),
	.bus_read_in(bus_read_in), .bus_select_out(bus_select_out),
	.bus_rdata_valid_out(bus_rdata_valid_out), .base_switch_in(base_switch_in),
	.monitor_mode_in(monitor_mode_in), .drive_enable_n_in(drive_enable_n_in),
	.terminal_data_line_out(terminal_data_line_out),
	.terminal_data_oe_n_out(terminal_data_oe_n_out),
	.write_strobe_n_out(write_strobe_n_out), .led_out(led_out), .relay_out(relay_out));

// ===== test/epio_terminal.sv
// Purpose: terminal-side model of the shared data lines
// Assumes: terminal drives whenever the port is released
// Notes: no fight modelled, the terminal always yields
`timescale 1ns/100ps
module epio_terminal (
	input wire logic [63:0] port_data_in,
	input wire logic [7:0] port_oe_n_in,
	input wire logic [63:0] term_data_in,
	output logic [63:0] line_out
);
	// port drives while its enable is low, else the terminal does
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			line_out[8*k +: 8] = port_oe_n_in[k] ? term_data_in[8*k +: 8] : port_data_in[8*k +: 8];
		end
	end
endmodule

// ===== test/test_epio_top.sv
// Purpose: self-checking bench for the eight-port i/o block
// Assumes: base switches 07h, so ports sit at 38h..3fh
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module test_epio_top;
	logic clock_in = 1'h0, rst_in = 1'h1, wr = 1'h0, rd = 1'h0, mon = 1'h1, sel, rv;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat, oe_n, den_n = 8'hff, gate = 8'h00, stb_n, led;
	logic [63:0] dout, line, term = 64'h0;
	logic [1:0] relay;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	epio_top i_dut (.clock_in(clock_in), .rst_in(rst_in), .bus_addr_in(addr),
		.bus_wdata_in(wd), .bus_write_in(wr), .bus_read_in(rd), .bus_rdata_out(rdat),
		.bus_rdata_valid_out(rv), .bus_select_out(sel), .base_switch_in(5'h07),
		.spare_switch_in(3'h5), .switch_bank_in(8'h3c), .monitor_mode_in(mon),
		.coupler_in(2'h2), .terminal_data_line_in(line), .terminal_data_line_out(dout),
		.terminal_data_oe_n_out(oe_n), .drive_enable_n_in(den_n), .capture_gate_in(gate),
		.write_strobe_n_out(stb_n), .led_out(led), .relay_out(relay));
	epio_terminal i_term (.port_data_in(dout), .port_oe_n_in(oe_n), .term_data_in(term),
		.line_out(line));
	// clock and hang guard
	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			finish_test();
		end
	end
	task chk(string nm, logic [63:0] seen, logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wt(int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// one bus cycle, request held across the taking edge
	task bus(logic w, logic [7:0] a, logic [7:0] d);
		wt(1);
		wr = w;
		rd = ~w;
		addr = a;
		wd = d;
		wt(1);
		wr = 1'h0;
		rd = 1'h0;
	endtask
	task rdc(logic [7:0] a, logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk("rvalid", rv, 1'h1);
		chk("rdata", rdat, e);
	endtask
	task finish_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// main sequence
	initial begin
		wt(4);
		rst_in = 1'h0;
		chk("strobes", stb_n, 8'hff);
		chk("leds", led, 8'h00);
		for (int k = 0; k < 8; k++) if (k != 6) begin
			bus(1'h1, 8'h38 + k[7:0], 8'h11 * k[7:0]);
			chk("latch", dout[8*k +: 8], 8'h11 * k[7:0]);
		end
		chk("relays", relay, 2'h1);
		chk("leds", led, 8'h77);
		bus(1'h1, 8'h49, 8'hee);
		chk("latch", dout[15:8], 8'h11);
		bus(1'h0, 8'h49, 8'h00);
		chk("rvalid", rv, 1'h0);
		bus(1'h1, 8'h38, 8'h00);
		wt(99);
		chk("strobe", stb_n[0], 1'h1);
		wt(1);
		chk("strobe", stb_n[0], 1'h0);
		wt(100);
		chk("strobe", stb_n[0], 1'h1);
		bus(1'h1, 8'h3e, 8'h08);
		chk("oe", oe_n, 8'hf7);
		chk("line", line[31:24], 8'h33);
		bus(1'h1, 8'h3e, 8'h00);
		mon = 1'h0;
		den_n = 8'hfd;
		bus(1'h1, 8'h3e, 8'h66);
		chk("latch6", dout[55:48], 8'h66);
		chk("oe", oe_n, 8'hfd);
		chk("line", line[15:8], 8'h11);
		den_n = 8'hff;
		mon = 1'h1;
		term = 64'h000000e0_005c0000;
		gate = 8'h14;
		wt(1);
		gate = 8'h00;
		term = 64'h0;
		rdc(8'h3e, 8'heb);
		rdc(8'h3a, 8'h5c);
		rdc(8'h3c, 8'hf5);
		rdc(8'h3e, 8'hff);
		rdc(8'h3f, 8'h3c);
		finish_test();
	end
endmodule
